/* File: bench/lcf_frame_port_bench.sv */
// self-checking bench for the serial command frame port
`timescale 1ns/100ps
module lcf_frame_port_bench import lcf_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] status = 8'h00;
  logic sclk, cs_n, sdi, sdo, perr;
  logic [8:0] outs [0:8];
  logic [8:0] exp_reg [0:8];
  logic [15:0] prev_exp;
  logic [31:0] rx;
  logic [4:0] rd_list [0:6] = '{5'h03, 5'h05, 5'h08, 5'h10, 5'h0a, 5'h1f, 5'h01};
  int error_cnt = 0;
  int tests_run = 0;

  // core clock
  always #5 ref_clk = ~ref_clk;

  lcf_frame_port lcf_frame_port_inst (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n),
    .sclk_in(sclk), .chain_select_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo),
    .status_in(status),
    .control_out(outs[0]), .therm_limit_out(outs[2]),
    .peak1_out(outs[3]), .peak2_out(outs[4]),
    .off_time_setpoint1_out(outs[5]), .off_time_setpoint2_out(outs[6]),
    .max_off_time_setpoint1_out(outs[7]), .max_off_time_setpoint2_out(outs[8])
  );

  lcf_host_model lcf_host_model_inst (
    .sclk_out(sclk), .chain_select_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo)
  );

  // command frame with odd parity over all sixteen bits
  function automatic logic [15:0] mk_frame(input logic w, input logic [4:0] a,
                                           input logic [8:0] d);
    logic [15:0] f;
    f = {w, a, 1'b0, d};
    f[LCF_PAR_BIT] = ~^f;
    return f;
  endfunction : mk_frame

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    tests_run++;
    if (seen !== expv) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask : check

  // all setpoint outputs against the model
  task automatic check_outs();
    for (int i = 0; i <= 8; i++) begin
      if (i != 1) check({7'h00, outs[i]}, {7'h00, exp_reg[i]}, "setpoint");
    end
  endtask : check_outs

  // one frame; checks the reply of the previous one and updates the model
  task automatic op(input logic w, input logic [4:0] a, input logic [8:0] d, input logic bad);
    logic [15:0] f;
    f = mk_frame(w, a, d);
    if (bad) f[LCF_PAR_BIT] = ~f[LCF_PAR_BIT];
    lcf_host_model_inst.xfer({16'h0000, f}, 16, rx);
    check(rx[15:0], prev_exp, "reply");
    if (bad) begin
      prev_exp = 16'h0000;
      perr = 1'b1;
    end else if (w) begin
      prev_exp = mk_frame(1'b0, a, 9'h000);
      if (a == 5'h00 || (a >= 5'h02 && a <= LCF_ADDR_WR_LAST)) exp_reg[a[3:0]] = d;
      if (a == LCF_ADDR_SOFT_RESET_KEY && d == LCF_RESET_KEY) begin
        for (int i = 0; i <= 8; i++) exp_reg[i] = LCF_REG_RST;
      end
    end else if (a == LCF_ADDR_STATUS) begin
      prev_exp = mk_frame(1'b0, a, {status, perr});
      perr = 1'b0;
    end else begin
      prev_exp = mk_frame(1'b0, a, (a <= LCF_ADDR_WR_LAST) ? exp_reg[a[3:0]] : 9'h000);
    end
  endtask : op

  // per-test line
  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask : end_test

  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // watchdog at about twice the expected run length
  initial begin
    #400000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  // main sequence
  initial begin
    for (int i = 0; i <= 8; i++) exp_reg[i] = LCF_REG_RST;
    perr = 1'b0;
    prev_exp = LCF_REPLY_RST;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    status <= 8'h5a;
    repeat (3) @(posedge ref_clk);
    check_outs();
    end_test("defaults");
    // nonzero values keep off-time setpoints in their tested range
    for (int i = 0; i <= 8; i++) begin
      if (i != 1) op(1'b1, i[4:0], 9'h100 + 9'(i * 37), 1'b0);
    end
    check_outs();
    for (int i = 0; i <= 6; i++) op(1'b0, rd_list[i], 9'h000, 1'b0);
    end_test("write_read");
    op(1'b1, 5'h02, 9'h1aa, 1'b1);
    check_outs();
    op(1'b0, LCF_ADDR_STATUS, 9'h000, 1'b0);
    op(1'b0, LCF_ADDR_STATUS, 9'h000, 1'b0);
    end_test("parity");
    // farthest device's frame first, this device keeps the last one
    lcf_host_model_inst.xfer({mk_frame(1'b1, 5'h05, 9'h055), mk_frame(1'b1, 5'h06, 9'h0aa)},
                             32, rx);
    check(rx[31:16], prev_exp, "chain reply");
    check(rx[15:0], mk_frame(1'b1, 5'h05, 9'h055), "chain pass");
    exp_reg[6] = 9'h0aa;
    prev_exp = mk_frame(1'b0, 5'h06, 9'h000);
    check_outs();
    end_test("chain");
    op(1'b1, LCF_ADDR_SOFT_RESET_KEY, 9'h0c2, 1'b0);
    check_outs();
    op(1'b1, LCF_ADDR_SOFT_RESET_KEY, LCF_RESET_KEY, 1'b0);
    check_outs();
    op(1'b0, 5'h03, 9'h000, 1'b0);
    op(1'b0, LCF_ADDR_SOFT_RESET_KEY, 9'h000, 1'b0);
    op(1'b0, 5'h00, 9'h000, 1'b0);
    end_test("key_reset");
    // mid-run reset brings setpoints and reply back to defaults
    op(1'b1, 5'h04, 9'h0f0, 1'b0);
    check_outs();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i <= 8; i++) exp_reg[i] = LCF_REG_RST;
    prev_exp = LCF_REPLY_RST;
    perr = 1'b0;
    check_outs();
    op(1'b0, 5'h04, 9'h000, 1'b0);
    op(1'b0, 5'h00, 9'h000, 1'b0);
    end_test("mid_reset");
    results();
  end
endmodule : lcf_frame_port_bench

/* File: bench/lcf_host_model.sv */
// host side model shifting command frames into the chain port
`timescale 1ns/100ps
module lcf_host_model import lcf_pkg::*; (
  // serial link
  output logic sclk_out,
  output logic chain_select_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  localparam int HALF_NS = 32;

  // idle link: select high, clock parked low
  // select rises after time zero so the link start flags surely see the edge
  initial begin
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    #1;
    chain_select_n_out = 1'b1;
  end

  // shift nbits msb first, capture sdo on each rising clock
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = '0;
    chain_select_n_out = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi_out = tx[i];
      #HALF_NS sclk_out = 1'b1;
      rx[i] = sdo_in;
      #HALF_NS sclk_out = 1'b0;
    end
    #(LCF_HOST_SETTLE_US * 1000);
    sdi_out = ~sdi_out; // stale data must not look valid
    chain_select_n_out = 1'b1;
    #(LCF_CS_GAP_NS + 220);
  endtask : xfer
endmodule : lcf_host_model

/* File: core/lcf_frame_port.sv */
// serial command frame port with daisy chain shifter and key reset
//
// Overview of operation
// - frames are 16 bits, one per chained device, shifted while select is low.
// - bit 15 is the write flag, one for write, zero for read.
// - bits 14 to 10 carry the five-bit register address, decoded here.
// - bits 8 to 0 carry write data; reads leave them zero.
// - bit 9 makes the whole frame odd parity.
// - writing key 0x0c3 to the reset register restores all writable defaults.
// - reset register holds nothing; reads of it return zero.
`timescale 1ns/100ps
module lcf_frame_port import lcf_pkg::*; (
  // core clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // serial link
  input wire logic sclk_in,
  input wire logic chain_select_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  // device status
  input wire logic [7:0] status_in,
  // setpoint outputs
  output logic [8:0] control_out,
  output logic [8:0] therm_limit_out,
  output logic [8:0] peak1_out,
  output logic [8:0] peak2_out,
  output logic [8:0] off_time_setpoint1_out,
  output logic [8:0] off_time_setpoint2_out,
  output logic [8:0] max_off_time_setpoint1_out,
  output logic [8:0] max_off_time_setpoint2_out
);
  // link domain state
  logic [LCF_FRAME_W-1:0] link_sh_q;
  logic rx_started_q;
  logic tx_started_q;
  logic sdo_q;
  // core domain state
  logic cs_s;
  logic cs_d_q;
  logic frame_rise;
  lcf_phase_t phase_q;
  logic [LCF_FRAME_W-1:0] frame_q;
  logic [LCF_FRAME_W-1:0] reply_q;
  logic perr_q;
  // decode
  logic f_good;
  logic f_write;
  logic [LCF_ADDR_W-1:0] f_addr;
  logic [LCF_DATA_W-1:0] f_data;
  logic f_wr_ok;
  logic [LCF_IDX_W-1:0] f_idx;
  logic bank_wr;
  logic bank_clear;
  logic [LCF_DATA_W-1:0] bank_rd;
  logic [LCF_NUM_WR*LCF_DATA_W-1:0] words;
  logic [LCF_DATA_W-1:0] rep_data;

  // ---------------- link clock domain ----------------

  // shift in on rising edge, preloaded with the reply on the first edge
  always_ff @(posedge sclk_in) begin
    if (rx_started_q) begin
      link_sh_q <= {link_sh_q[LCF_FRAME_W-2:0], sdi_in};
    end else begin
      link_sh_q <= {reply_q[LCF_FRAME_W-2:0], sdi_in};
    end
  end

  // first rising edge of a frame seen; cleared while select is high
  always_ff @(posedge sclk_in or posedge chain_select_n_in) begin
    if (chain_select_n_in) begin
      rx_started_q <= 1'b0;
    end else begin
      rx_started_q <= 1'b1;
    end
  end

  // output bit changes on falling edge
  always_ff @(negedge sclk_in) begin
    sdo_q <= link_sh_q[LCF_FRAME_W-1];
  end

  // first falling edge of a frame seen
  always_ff @(negedge sclk_in or posedge chain_select_n_in) begin
    if (chain_select_n_in) begin
      tx_started_q <= 1'b0;
    end else begin
      tx_started_q <= 1'b1;
    end
  end

  // reply msb until the shifter takes over; chained data passes 16 bits late
  assign sdo_out = tx_started_q ? sdo_q : reply_q[LCF_FRAME_W-1];

  // ---------------- core clock domain ----------------

  // select crosses as a level
  lcf_sync2 u_cs_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(chain_select_n_in),
    .q_out(cs_s)
  );

  // select edge detect on synchronised level
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cs_d_q <= 1'b1;
    end else begin
      cs_d_q <= cs_s;
    end
  end
  assign frame_rise = cs_s & ~cs_d_q;

  // frame sequencer; shifter is still once select is high
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      phase_q <= LCF_PH_IDLE;
      frame_q <= LCF_REPLY_RST;
    end else begin
      case (phase_q)
        LCF_PH_IDLE: begin
          if (frame_rise) begin
            frame_q <= link_sh_q;
            phase_q <= LCF_PH_DECODE;
          end
        end
        LCF_PH_DECODE: begin
          phase_q <= LCF_PH_REPLY;
        end
        LCF_PH_REPLY: begin
          phase_q <= LCF_PH_IDLE;
        end
        default: begin
          phase_q <= LCF_PH_IDLE;
        end
      endcase
    end
  end

  // field decode
  assign f_good = ^frame_q;
  assign f_write = frame_q[LCF_WFLAG_BIT];
  assign f_addr = frame_q[LCF_ADDR_HI:LCF_ADDR_LO];
  assign f_data = frame_q[LCF_DATA_HI:0];
  assign f_wr_ok = (f_addr == LCF_ADDR_CONTROL) ||
                   (f_addr > LCF_ADDR_STATUS && f_addr <= LCF_ADDR_WR_LAST);

  // address to bank index: control first, then addresses 2 to 8
  always_comb begin
    f_idx = '0;
    if (f_addr != LCF_ADDR_CONTROL) begin
      f_idx = LCF_IDX_W'(f_addr - 5'h01);
    end
  end

  // write and key strobes, only for good frames
  assign bank_wr = (phase_q == LCF_PH_DECODE) && f_good && f_write && f_wr_ok;
  assign bank_clear = (phase_q == LCF_PH_DECODE) && f_good && f_write &&
                      (f_addr == LCF_ADDR_SOFT_RESET_KEY) && (f_data == LCF_RESET_KEY);

  lcf_reg_bank u_bank (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(bank_clear),
    .wr_en_in(bank_wr),
    .wr_idx_in(f_idx),
    .wr_data_in(f_data),
    .rd_idx_in(f_idx),
    .rd_data_out(bank_rd),
    .words_out(words)
  );

  // sticky parity error, set wins over the status read clear
  // clear waits for the reply phase so the reply still carries the flag
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      perr_q <= 1'b0;
    end else if (phase_q == LCF_PH_DECODE && !f_good) begin
      perr_q <= 1'b1;
    end else if (phase_q == LCF_PH_REPLY && f_good && !f_write &&
                 f_addr == LCF_ADDR_STATUS) begin
      perr_q <= 1'b0;
    end
  end

  // reply payload for reads; key register and unmapped read zero
  always_comb begin
    rep_data = '0;
    if (!f_write && f_wr_ok) begin
      rep_data = bank_rd;
    end else if (!f_write && f_addr == LCF_ADDR_STATUS) begin
      rep_data = {status_in, perr_q};
    end else if (f_addr == LCF_ADDR_SOFT_RESET_KEY) begin
      rep_data = LCF_SOFT_RESET_KEY_RST;
    end
  end

  // reply word, odd parity; a dropped frame answers all zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      reply_q <= LCF_REPLY_RST;
    end else if (phase_q == LCF_PH_REPLY) begin
      if (f_good) begin
        reply_q <= {1'b0, f_addr, ~^{f_addr, rep_data}, rep_data};
      end else begin
        reply_q <= LCF_REPLY_RST;
      end
    end
  end

  // setpoints straight from the bank flops
  assign control_out = words[0*LCF_DATA_W +: LCF_DATA_W];
  assign therm_limit_out = words[1*LCF_DATA_W +: LCF_DATA_W];
  assign peak1_out = words[2*LCF_DATA_W +: LCF_DATA_W];
  assign peak2_out = words[3*LCF_DATA_W +: LCF_DATA_W];
  assign off_time_setpoint1_out = words[4*LCF_DATA_W +: LCF_DATA_W];
  assign off_time_setpoint2_out = words[5*LCF_DATA_W +: LCF_DATA_W];
  assign max_off_time_setpoint1_out = words[6*LCF_DATA_W +: LCF_DATA_W];
  assign max_off_time_setpoint2_out = words[7*LCF_DATA_W +: LCF_DATA_W];

  // ---------------- assertions ----------------

  // link shifter takes one bit per rising edge
  a_shift_in: assert property (@(posedge sclk_in) disable iff (chain_select_n_in)
    rx_started_q |=> link_sh_q[0] == $past(sdi_in))
    else $error("shifter lost a serial bit");

  // frame captured one cycle after the synchronised select rise
  a_frame_take: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    frame_rise && phase_q == LCF_PH_IDLE |=> phase_q == LCF_PH_DECODE &&
      frame_q == $past(link_sh_q))
    else $error("frame not captured at select release");

  // a read frame never writes
  a_read_no_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_DECODE && !f_write |=> $stable(words))
    else $error("read frame changed a register");

  // a good write lands at the decoded word
  a_addr_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    bank_wr && !bank_clear |=> words[$past(f_idx)*LCF_DATA_W +: LCF_DATA_W] == $past(f_data))
    else $error("write data not stored at addressed register");

  // even parity frame leaves the registers alone and answers all zero
  a_parity_drop: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_DECODE && !f_good |=> $stable(words) ##1 reply_q == LCF_REPLY_RST)
    else $error("bad parity frame was acted on");

  // key write restores every default
  a_key_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    bank_clear |=> words == '0)
    else $error("key write did not restore defaults");

  // wrong key value does nothing
  a_wrong_key: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_DECODE && f_write && f_addr == LCF_ADDR_SOFT_RESET_KEY &&
      f_data != LCF_RESET_KEY |=> $stable(words))
    else $error("wrong key changed registers");

  // key register reads zero
  a_key_read_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_DECODE && f_good && f_addr == LCF_ADDR_SOFT_RESET_KEY
      |=> ##1 reply_q[LCF_DATA_HI:0] == '0)
    else $error("key register read not zero");

  // read reply carries the register contents
  a_read_reply: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_DECODE && f_good && !f_write && f_wr_ok
      |=> ##1 reply_q[LCF_DATA_HI:0] == words[$past(f_idx, 2)*LCF_DATA_W +: LCF_DATA_W])
    else $error("read reply differs from register");

  // reply words are odd parity
  a_reply_odd: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_REPLY && f_good |=> ^reply_q)
    else $error("reply parity is even");

  // status read returns the flag before clearing it
  a_status_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_REPLY && f_good && !f_write && f_addr == LCF_ADDR_STATUS
      |=> reply_q[0] == $past(perr_q) && !perr_q)
    else $error("status read lost or kept the parity error flag");

  // first reply bit stands before the first falling edge
  a_sdo_first: assert property (@(posedge sclk_in) disable iff (chain_select_n_in)
    !tx_started_q |-> sdo_out == reply_q[LCF_FRAME_W-1])
    else $error("first reply bit not on serial output");

  // main scenarios
  c_read: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_DECODE && f_good && !f_write && f_wr_ok);
  c_write: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) bank_wr);
  c_key: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) bank_clear);
  c_perr: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_DECODE && !f_good);
  c_status: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    phase_q == LCF_PH_REPLY && f_good && !f_write && f_addr == LCF_ADDR_STATUS && perr_q);
endmodule : lcf_frame_port

/* File: core/lcf_pkg.sv */
// shared constants and types for the serial command frame block
package lcf_pkg;
  // frame layout
  localparam int LCF_FRAME_W = 16;
  localparam int LCF_DATA_W = 9;
  localparam int LCF_ADDR_W = 5;
  localparam int LCF_WFLAG_BIT = 15;
  localparam int LCF_ADDR_HI = 14;
  localparam int LCF_ADDR_LO = 10;
  localparam int LCF_PAR_BIT = 9;
  localparam int LCF_DATA_HI = 8;
  // register addresses
  localparam logic [4:0] LCF_ADDR_CONTROL = 5'h00;
  localparam logic [4:0] LCF_ADDR_STATUS = 5'h01;
  localparam logic [4:0] LCF_ADDR_WR_LAST = 5'h08;
  localparam logic [4:0] LCF_ADDR_SOFT_RESET_KEY = 5'h10;
  // writable bank
  localparam int LCF_NUM_WR = 8;
  localparam int LCF_IDX_W = 3;
  localparam logic [8:0] LCF_REG_RST = 9'h000;
  localparam logic [8:0] LCF_SOFT_RESET_KEY_RST = 9'h000;
  localparam logic [8:0] LCF_RESET_KEY = 9'h0c3;
  localparam logic [15:0] LCF_REPLY_RST = 16'h0000;
  // least chain select high time the core needs between frames
  localparam int LCF_CLK_PERIOD_NS = 10;
  localparam int LCF_CS_GAP_NS = 80;
  localparam int LCF_CS_GAP_CYC = (LCF_CS_GAP_NS + LCF_CLK_PERIOD_NS - 1) / LCF_CLK_PERIOD_NS;
  // host wait before releasing chain select
  localparam int LCF_HOST_SETTLE_US = 5;
  // frame handling phases
  typedef enum logic [1:0] {
    LCF_PH_IDLE = 2'b00,
    LCF_PH_DECODE = 2'b01,
    LCF_PH_REPLY = 2'b10
  } lcf_phase_t;
endpackage : lcf_pkg

/* File: core/lcf_reg_bank.sv */
// writable setpoint bank with registered read port
`timescale 1ns/100ps
module lcf_reg_bank import lcf_pkg::*; (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // write side
  input wire logic clear_in,
  input wire logic wr_en_in,
  input wire logic [LCF_IDX_W-1:0] wr_idx_in,
  input wire logic [LCF_DATA_W-1:0] wr_data_in,
  // read side
  input wire logic [LCF_IDX_W-1:0] rd_idx_in,
  output logic [LCF_DATA_W-1:0] rd_data_out,
  output logic [LCF_NUM_WR*LCF_DATA_W-1:0] words_out
);
  logic [LCF_DATA_W-1:0] mem_q [LCF_NUM_WR];

  // storage, cleared by reset or the key write
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_in) begin
      for (int i = 0; i < LCF_NUM_WR; i++) begin
        mem_q[i] <= LCF_REG_RST;
      end
    end else if (wr_en_in) begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
  end

  // registered read data
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= LCF_REG_RST;
    end else begin
      rd_data_out <= mem_q[rd_idx_in];
    end
  end

  // flat view of every word
  genvar g;
  generate
    for (g = 0; g < LCF_NUM_WR; g++) begin : g_words
      assign words_out[g*LCF_DATA_W +: LCF_DATA_W] = mem_q[g];
    end
  endgenerate
endmodule : lcf_reg_bank

/* File: core/lcf_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
module lcf_sync2 import lcf_pkg::*; (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // level in and out
  input wire logic d_in,
  output logic q_out
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b1;
      q_out <= 1'b1;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule : lcf_sync2
